// ==== bcf_top.sv ====
// Block RAM with embedded FIFO controller and width conversion
// Operation
// RL1: Reads and writes happen only on clock edges
// RL2: Each port runs on its own rate
// RL3: Shapes 4kx1, 2kx2, 1kx4 and 512x9
// RL4: Two-port shapes 512x9 and 256x18
// RL5: Writes registered; read optionally pipelined
// RL6: Controller makes addresses and four flags
// RL7: RAM mode uses user addresses only
// RL8: FIFO mode muxes controller addresses in
// RL9: Write and read widths chosen independently
// RL10: Narrow ports leave the ninth bit unused
// RL11: Full blocks writes, empty blocks reads
`timescale 1ns/1ps
module bcf_top #(
    parameter logic [12:0] AF_LVL = bcf_pkg::AF_LVL_RST,
    parameter logic [12:0] AE_LVL = bcf_pkg::AE_LVL_RST
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic fifo_mode,
    input wire logic [2:0] write_width_select,
    input wire logic [2:0] read_width_select,
    input wire logic read_pipelined,
    input wire logic wr_port_en,
    input wire logic wr_valid,
    input wire logic [11:0] wr_addr,
    input wire logic [17:0] wr_data,
    output logic wr_ready,
    input wire logic rd_port_en,
    input wire logic rd_req,
    input wire logic [11:0] rd_addr,
    output logic [17:0] rd_data,
    output logic rd_valid,
    output logic full_flag,
    output logic empty_flag,
    output logic almost_full_flag,
    output logic almost_empty_flag
);
    bcf_ram_if ram_if ();

    // Write buffer signals: address over data
    logic [29:0] buf_out;
    logic buf_valid, wr_go;
    logic [11:0] wq, rq; // Quanta addresses after the mux
    logic [2:0] wsh, rsh; // Width shifts
    logic [12:0] wstep, rstep; // Quanta per access
    logic rd_fire;

    // Controller state
    // Pointers count quanta, so a row is 16 steps and a word 8;
    // mixing widths on the two ports then needs no extra scaling.
    // Level is one bit wider than the pointers so that a completely
    // full array (4096 quanta) can be told apart from an empty one.
    // Pointers wrap freely at 4096 quanta, the array size.
    // Write and read pointers
    logic [11:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [12:0] lvl_ff, nxt_lvl;
    logic full_ff, nxt_full, empty_ff, nxt_empty;
    logic af_ff, nxt_af, ae_ff, nxt_ae;

    // Read path state
    logic v1_ff, nxt_v1, v2_ff, nxt_v2, ov_ff, nxt_ov;
    logic [4:0] base_ff, nxt_base;
    logic [17:0] keep_ff, nxt_keep; // Lanes kept on read
    logic [17:0] slice, p2_ff, nxt_p2, od_ff, nxt_od;

    // Incoming writes wait here; back-pressure reaches wr_ready
    // Address and data travel together so a stalled entry keeps both.
    // Stalling here instead of dropping keeps user data safe when
    // the array is full; the cost is up to eight entries of latency.
    // Entries leave in acceptance order, one per write enable.
    bcf_buf #(.WIDTH(30), .DEPTH(bcf_pkg::BUF_DEPTH)) u_buf (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data({wr_addr, wr_data}),
        .out_valid(buf_valid),
        .out_ready(wr_go),
        .out_data(buf_out)
    );

    bcf_ram #(.DEPTH(bcf_pkg::ROWS)) u_ram (
        .sys_clk(sys_clk),
        .port(ram_if.mem)
    );

    // Width decode per port
    // Codes above the widest act as the widest, never as unknown.
    // A step is the number of quanta one access moves the pointer.
    // Both ports decode on their own, allowing bus conversion.
    assign wsh = bcf_pkg::width_shift(write_width_select);
    assign rsh = bcf_pkg::width_shift(read_width_select);
    assign wstep = 13'h0001 << wsh;
    assign rstep = 13'h0001 << rsh;

    // RL2: each port moves on its own enable
    // RL11: full stalls the buffer drain
    assign wr_go = wr_port_en && buf_valid && !(fifo_mode && full_ff);
    // RL11: empty ignores read requests
    assign rd_fire = rd_port_en && rd_req && !(fifo_mode && empty_ff);

    // RL7: user addresses in RAM mode
    // RL8: controller pointers in FIFO mode
    assign wq = fifo_mode ? wp_ff : (buf_out[29:18] << wsh);
    assign rq = fifo_mode ? rp_ff : (rd_addr << rsh);

    // RL1: all array access registered inside the RAM
    // RL9: write and read lanes follow their own widths
    // RL10: narrow lanes never reach bit 8 of a word
    // Row strobe from wr_go; row select straight from the muxed address
    assign ram_if.we = wr_go;
    assign ram_if.wr_row = wq[11:4];
    // RL3: narrow shapes pick one lane group
    // RL4: wide shape writes the whole row
    // Lanes outside the mask keep their old contents.
    assign ram_if.wr_mask = bcf_pkg::lane_mask(wq, write_width_select);
    assign ram_if.wr_data =
        buf_out[17:0] << bcf_pkg::lane_base(wq, write_width_select);
    assign ram_if.re = rd_fire;
    assign ram_if.rd_row = rq[11:4];

    // RL6: controller pointers, level and flags
    // RAM mode leaves pointers and level untouched; flags are still recomputed from the level and the current steps.
    // A write and a read in one cycle both adjust the level.
    // Flags are worked out from the next level, so they register
    // on the same edge as the access that moves the level.
    // Hazard: a late flag would let one extra write slip in.
    always_comb begin
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        nxt_lvl = lvl_ff;
        if (fifo_mode && wr_go) begin
            nxt_wp = wp_ff + wstep[11:0];
            nxt_lvl = nxt_lvl + wstep;
        end
        if (fifo_mode && rd_fire) begin
            nxt_rp = rp_ff + rstep[11:0];
            nxt_lvl = nxt_lvl - rstep;
        end
        // Full once the next write no longer fits
        nxt_full = ({1'b0, nxt_lvl} + {1'b0, wstep}) > {1'b0, bcf_pkg::Q_CAP};
        nxt_empty = nxt_lvl < rstep;
        nxt_af = nxt_lvl >= AF_LVL;
        nxt_ae = nxt_lvl <= AE_LVL;
    end

    // Register controller state
    // Reset leaves the FIFO empty: empty and almost empty high.
    // Array contents survive reset; this block resets only the pointers, level and flags.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            lvl_ff <= '0;
            full_ff <= 1'b0;
            empty_ff <= 1'b1;
            af_ff <= 1'b0;
            ae_ff <= 1'b1;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            lvl_ff <= nxt_lvl;
            full_ff <= nxt_full;
            empty_ff <= nxt_empty;
            af_ff <= nxt_af;
            ae_ff <= nxt_ae;
        end
    end

    // Pick the read lanes out of the registered row
    assign slice = (ram_if.rd_data >> base_ff) & keep_ff;

    // RL5: read path, one extra stage when pipelined
    // Lane offset and width are captured when the read is taken,
    // since the array answers one cycle later.
    // Nonpipelined: valid two cycles after taking the request.
    // Pipelined: one more cycle, for a shorter path to the pins.
    // Output data holds until the next answer.
    always_comb begin
        nxt_v1 = rd_fire;
        nxt_base = rd_fire ? bcf_pkg::lane_base(rq, read_width_select)
                           : base_ff;
        nxt_keep = rd_fire ? ((18'h00001
                   << bcf_pkg::width_bits(read_width_select)) - 18'h00001)
                           : keep_ff;
        nxt_v2 = v1_ff;
        nxt_p2 = v1_ff ? slice : p2_ff;
        nxt_ov = read_pipelined ? v2_ff : v1_ff;
        nxt_od = od_ff;
        if (read_pipelined && v2_ff) begin
            nxt_od = p2_ff;
        end else if (!read_pipelined && v1_ff) begin
            nxt_od = slice;
        end
    end

    // Register read path
    // Reset clears the valid chain so no stale answer appears.
    // Data registers clear too, so rd_data reads zero after reset.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            v1_ff <= 1'b0;
            v2_ff <= 1'b0;
            ov_ff <= 1'b0;
            base_ff <= '0;
            keep_ff <= '0;
            p2_ff <= '0;
            od_ff <= '0;
        end else begin
            v1_ff <= nxt_v1;
            v2_ff <= nxt_v2;
            ov_ff <= nxt_ov;
            base_ff <= nxt_base;
            keep_ff <= nxt_keep;
            p2_ff <= nxt_p2;
            od_ff <= nxt_od;
        end
    end

    // Outputs straight from flops
    // Keeps output timing independent of the width decode logic.
    // Flags are levels; rd_valid is high for one cycle per answer.
    assign rd_data = od_ff;
    assign rd_valid = ov_ff;
    assign full_flag = full_ff;
    assign empty_flag = empty_ff;
    assign almost_full_flag = af_ff;
    assign almost_empty_flag = ae_ff;

    // Checks, all in the system clock domain
    // Both port rates are enables on this one clock, so a single
    // default clocking serves every property below.
    // Reset disables all checks; flags settle on the first edge.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_sync_write: assert property (ram_if.we |-> wr_port_en) // RL1
        else $error("array written without write enable");
    a_port_enable: assert property (rd_fire |-> rd_port_en) // RL2
        else $error("read taken without read enable");
    a_narrow_count: assert property ( // RL3
        ram_if.we && write_width_select != bcf_pkg::WID_18 |->
        $countones(ram_if.wr_mask)
            == bcf_pkg::width_bits(write_width_select))
        else $error("narrow write lane count wrong");
    a_wide_mask: assert property ( // RL4
        ram_if.we && write_width_select == bcf_pkg::WID_18 |->
        &ram_if.wr_mask)
        else $error("18-bit write missed lanes");
    a_read_flat: assert property ( // RL5
        rd_fire && !read_pipelined ##1 !read_pipelined |-> ##1 rd_valid)
        else $error("nonpipelined read not two cycles");
    a_read_piped: assert property ( // RL5
        rd_fire && read_pipelined ##1 read_pipelined[*2] |-> ##1 rd_valid)
        else $error("pipelined read not three cycles");
    a_level_match: assert property ( // RL6
        lvl_ff[11:0] == wp_ff - rp_ff)
        else $error("level disagrees with pointers");
    a_ram_addr: assert property ( // RL7
        !fifo_mode && rd_fire |-> ram_if.rd_row == 8'((rd_addr << rsh) >> 4))
        else $error("RAM mode read row wrong");
    a_fifo_addr: assert property ( // RL8
        fifo_mode && rd_fire ##1 fifo_mode && rd_fire |->
        ram_if.rd_row == 8'(($past(rp_ff) + rstep[11:0]) >> 4))
        else $error("FIFO read row did not advance");
    a_conv_data: assert property ( // RL9
        rd_valid |-> (rd_data & ~keep_ff) == 18'h00000)
        else $error("read data wider than read port");
    a_ninth_free: assert property ( // RL10
        ram_if.we && write_width_select < bcf_pkg::WID_9 |->
        !ram_if.wr_mask[8] && !ram_if.wr_mask[17])
        else $error("narrow write touched ninth bit");
    a_full_block: assert property ( // RL11
        fifo_mode && full_flag |-> !ram_if.we ##1 $stable(wp_ff))
        else $error("write taken while full");
    a_empty_block: assert property ( // RL11
        fifo_mode && empty_flag |=> $stable(rp_ff))
        else $error("read taken while empty");

    c_fifo_full: cover property (fifo_mode && full_flag);
    c_conv_18_9: cover property (ram_if.we
        && write_width_select == bcf_pkg::WID_18
        && read_width_select == bcf_pkg::WID_9);
    c_piped_read: cover property (rd_valid && read_pipelined);
    c_buf_stall: cover property (wr_valid && !wr_ready);
endmodule : bcf_top

// ==== bcf_pkg.sv ====
// Shared constants, width codes and lane helpers for the block RAM FIFO
package bcf_pkg;
    // Port width select codes
    localparam logic [2:0] WID_1 = 3'h0;
    localparam logic [2:0] WID_2 = 3'h1;
    localparam logic [2:0] WID_4 = 3'h2;
    localparam logic [2:0] WID_9 = 3'h3;
    localparam logic [2:0] WID_18 = 3'h4;
    // Array shape: 256 rows of two 9-bit words
    localparam int unsigned ROWS = 256;
    localparam int unsigned ROW_W = 18;
    localparam int unsigned ROW_AW = 8;
    localparam int unsigned HALF_W = 9;
    // Quanta address: one eighth of a 9-bit word
    localparam int unsigned Q_W = 12;
    localparam logic [12:0] Q_CAP = 13'h1000;
    localparam logic [12:0] AF_LVL_RST = 13'h0E00;
    localparam logic [12:0] AE_LVL_RST = 13'h0200;
    // Write buffer shape
    localparam int unsigned BUF_DEPTH = 8;
    localparam int unsigned ADDR_W = 12;
    // Port rate limit against the system clock
    localparam int unsigned PORT_FMAX_MHZ = 350;
    localparam int unsigned SYS_CLK_MHZ = 100;
    localparam int unsigned PORT_MIN_GAP_CYC =
        (SYS_CLK_MHZ + PORT_FMAX_MHZ - 1) / PORT_FMAX_MHZ;

    // Data bits carried by a port width
    function automatic logic [4:0] width_bits(input logic [2:0] c);
        case (c)
            WID_1: width_bits = 5'h01;
            WID_2: width_bits = 5'h02;
            WID_4: width_bits = 5'h04;
            WID_9: width_bits = 5'h09;
            default: width_bits = 5'h12;
        endcase
    endfunction : width_bits

    // Quanta per port address, as a shift
    function automatic logic [2:0] width_shift(input logic [2:0] c);
        case (c)
            WID_1: width_shift = 3'h0;
            WID_2: width_shift = 3'h1;
            WID_4: width_shift = 3'h2;
            WID_9: width_shift = 3'h3;
            default: width_shift = 3'h4;
        endcase
    endfunction : width_shift

    // Lowest row bit touched by an access
    function automatic logic [4:0] lane_base(input logic [11:0] q,
                                             input logic [2:0] c);
        logic [4:0] b;
        b = q[3] ? 5'h09 : 5'h00;
        if (c == WID_1 || c == WID_2 || c == WID_4) begin
            b = b + {2'h0, q[2:0]};
        end
        lane_base = (c == WID_9 || c == WID_1 || c == WID_2
                     || c == WID_4) ? b : 5'h00;
    endfunction : lane_base

    // Row bits touched by an access
    function automatic logic [17:0] lane_mask(input logic [11:0] q,
                                              input logic [2:0] c);
        logic [17:0] m;
        m = (18'h00001 << width_bits(c)) - 18'h00001;
        lane_mask = m << lane_base(q, c);
    endfunction : lane_mask
endpackage : bcf_pkg

// ==== bcf_ram_if.sv ====
// Carrier between the controller and the storage array
`timescale 1ns/1ps
interface bcf_ram_if;
    logic we; // Row write strobe
    logic [7:0] wr_row; // Row written
    logic [17:0] wr_data; // Data placed on its lanes
    logic [17:0] wr_mask; // Lanes written
    logic re; // Row read strobe
    logic [7:0] rd_row; // Row read
    logic [17:0] rd_data; // Registered row
    modport ctrl(output we, wr_row, wr_data, wr_mask, re, rd_row,
                 input rd_data);
    modport mem(input we, wr_row, wr_data, wr_mask, re, rd_row,
                output rd_data);
endinterface : bcf_ram_if

// ==== bcf_ram.sv ====
// Storage array with masked synchronous write and synchronous read
`timescale 1ns/1ps
module bcf_ram #(
    parameter int unsigned DEPTH = bcf_pkg::ROWS
) (
    input wire logic sys_clk,
    bcf_ram_if.mem port
);
    // Contents are not reset, as in any block RAM
    logic [bcf_pkg::ROW_W-1:0] mem_q [DEPTH];
    logic [bcf_pkg::ROW_W-1:0] rd_data_ff;

    // Per-lane masked write; read returns old data on a clash
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < bcf_pkg::ROW_W; i++) begin
            if (port.we && port.wr_mask[i]) begin
                mem_q[port.wr_row][i] <= port.wr_data[i];
            end
        end
        if (port.re) begin
            rd_data_ff <= mem_q[port.rd_row];
        end
    end
    assign port.rd_data = rd_data_ff;
endmodule : bcf_ram

// ==== bcf_buf.sv ====
// Small valid/ready FIFO that holds write requests
`timescale 1ns/1ps
module bcf_buf #(
    parameter int unsigned WIDTH = 30,
    parameter int unsigned DEPTH = bcf_pkg::BUF_DEPTH
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH]; // Entries
    logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy; // Registered not-full
    logic push, pop;

    assign push = in_valid && rdy_ff;
    assign pop = out_valid && out_ready;
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_q[rp_ff];
    assign in_ready = rdy_ff;

    // Next pointers and count
    always_comb begin
        nxt_wp = push ? ((wp_ff == PTR_LAST) ? '0 : wp_ff + 1'b1) : wp_ff;
        nxt_rp = pop ? ((rp_ff == PTR_LAST) ? '0 : rp_ff + 1'b1) : rp_ff;
        nxt_cnt = cnt_ff;
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
        // Ready falls as the last slot fills
        nxt_rdy = (nxt_cnt != CNT_FULL);
    end

    // Register pointer state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
        end
    end

    // Entry storage needs no reset
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wp_ff] <= in_data;
        end
    end

    a_buf_no_overrun: assert property (@(posedge sys_clk) disable iff (srst)
        cnt_ff == CNT_FULL |-> !rdy_ff)
        else $error("write buffer accepted data while full");
endmodule : bcf_buf

// ==== bcf_user.sv ====
// User fabric model: port rate enables and consumer read request
`timescale 1ns/1ps
module bcf_user (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic slow,
    input wire logic rd_want,
    output logic wr_port_en,
    output logic rd_port_en,
    output logic rd_req
);
    logic [1:0] rd_cnt_ff; // Read rate phase
    logic wr_tog_ff; // Write rate phase
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_cnt_ff <= 2'h0;
            wr_tog_ff <= 1'b0;
        end else begin
            rd_cnt_ff <= (rd_cnt_ff == 2'h2) ? 2'h0 : rd_cnt_ff + 2'h1;
            wr_tog_ff <= ~wr_tog_ff;
        end
    end
    // Slow side stalls: write every second, read every third cycle
    assign wr_port_en = ~slow | wr_tog_ff;
    assign rd_port_en = ~slow | (rd_cnt_ff == 2'h0);
    assign rd_req = rd_want;
endmodule : bcf_user

// ==== bcf_top_tb.sv ====
// Self-checking bench for the block RAM FIFO
`timescale 1ns/1ps
module bcf_top_tb;
    logic sys_clk = 1'b0; // 100 MHz clock
    logic srst, fifo_mode, read_pipelined, wr_valid, slow, rd_want;
    logic [2:0] write_width_select, read_width_select;
    logic [11:0] wr_addr, rd_addr;
    logic [17:0] wr_data, rd_data, d;
    logic wr_ready, rd_valid, full_flag, empty_flag;
    logic almost_full_flag, almost_empty_flag;
    logic wr_port_en, rd_port_en, rd_req;
    logic [17:0] exp_q[$]; // Expected read words, oldest first
    int fail_count = 0;
    int n_checks = 0;
    int j, c, p, n;
    logic [11:0] a;

    // Clock
    always #5 sys_clk = ~sys_clk;

    bcf_top i_dut (.sys_clk(sys_clk), .srst(srst), .fifo_mode(fifo_mode),
        .write_width_select(write_width_select),
        .read_width_select(read_width_select),
        .read_pipelined(read_pipelined), .wr_port_en(wr_port_en),
        .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_ready(wr_ready), .rd_port_en(rd_port_en), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .full_flag(full_flag), .empty_flag(empty_flag),
        .almost_full_flag(almost_full_flag),
        .almost_empty_flag(almost_empty_flag));

    bcf_user i_user (.sys_clk(sys_clk), .srst(srst), .slow(slow),
        .rd_want(rd_want), .wr_port_en(wr_port_en),
        .rd_port_en(rd_port_en), .rd_req(rd_req));

    // Compare and count
    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        n_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, want);
        end
    endtask : check

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // A wait ran out
    task automatic give_up();
        fail_count++;
        stop_test();
    endtask : give_up

    // Flags as {full, empty, almost full, almost empty}
    task automatic flags(input logic [3:0] e);
        check(18'({full_flag, empty_flag, almost_full_flag,
                   almost_empty_flag}), 18'(e));
    endtask : flags

    // Reset, held 12 cycles
    task automatic rst_dut();
        srst <= 1'b1;
        repeat (12) @(posedge sys_clk);
        check(18'(wr_ready), 18'h00000);
        flags(4'h5);
        srst <= 1'b0;
        @(posedge sys_clk);
    endtask : rst_dut

    // Write request, valid left high for back-to-back use
    task automatic wr(input logic [11:0] wa, input logic [17:0] wd,
                      input bit q);
        int k;
        if (q) exp_q.push_back(wd);
        wr_addr <= wa;
        wr_data <= wd;
        wr_valid <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge sys_clk);
            if (wr_ready === 1'b1) break;
        end
        if (k == 200) give_up();
    endtask : wr

    // Single read with latency measured from the taking edge
    task automatic rd(input logic [11:0] ra, input logic [17:0] e);
        int k;
        exp_q.push_back(e);
        rd_addr <= ra;
        rd_want <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (rd_port_en === 1'b1) break;
        end
        if (k == 20) give_up();
        rd_want <= 1'b0;
        for (k = 1; k < 20; k++) begin
            @(posedge sys_clk);
            if (rd_valid === 1'b1) break;
        end
        check(18'(k), 18'(2 + read_pipelined));
    endtask : rd

    // Expected bits of a row seen at a read address of width code sh
    function automatic logic [17:0] lane(input logic [17:0] r,
                                         input logic [11:0] ra,
                                         input int sh);
        logic [15:0] q;
        int b;
        q = 16'(ra) << sh;
        b = (q[3] ? 9 : 0) + (sh < 3 ? int'(q[2:0]) : 0);
        if (sh == 4) return r;
        return (r >> b) &
            ((18'h00001 << (sh == 3 ? 9 : (1 << sh))) - 18'h00001);
    endfunction : lane

    // Monitor: every answer takes the oldest expected word
    always @(posedge sys_clk) begin
        if (srst === 1'b0 && rd_valid === 1'b1) begin
            if (exp_q.size() == 0) check(18'h3FFFF, 18'h00000);
            else check(rd_data, exp_q.pop_front());
        end
    end

    // Main sequence
    initial begin
        srst = 1'b1;
        fifo_mode = 1'b0;
        write_width_select = bcf_pkg::WID_18;
        read_width_select = bcf_pkg::WID_18;
        read_pipelined = 1'b0;
        wr_valid = 1'b0;
        wr_addr = 12'h000;
        wr_data = 18'h00000;
        rd_addr = 12'h000;
        slow = 1'b1;
        rd_want = 1'b0;
        void'($urandom(53));
        // RAM mode: one wide row, read back at every width
        rst_dut();
        d = 18'($urandom());
        wr(12'h005, d, 1'b0);
        wr_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        for (p = 0; p < 2; p++) begin
            for (c = 0; c < 5; c++) begin
                read_pipelined <= p[0];
                read_width_select <= 3'(c);
                @(posedge sys_clk);
                for (j = 0; j < (1 << (4 - c)); j++) begin
                    a = 12'(5 << (4 - c)) + 12'(j);
                    rd(a, lane(d, a, c));
                end
            end
        end
        // Narrow writes leave the ninth bits alone
        write_width_select <= bcf_pkg::WID_4;
        @(posedge sys_clk);
        for (j = 0; j < 4; j++) wr(12'(20 + j), 18'h00000, 1'b0);
        wr_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(12'h005, d & 18'h20100);
        // FIFO mode: reads on empty are ignored
        fifo_mode <= 1'b1;
        write_width_select <= bcf_pkg::WID_18;
        rst_dut();
        rd_want <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rd_want <= 1'b0;
        // Fill array and buffer until writes are refused
        for (j = 0; j < 264; j++) wr(12'($urandom()), 18'($urandom()), 1'b1);
        wr_valid <= 1'b0;
        repeat (40) @(posedge sys_clk);
        check(18'(wr_ready), 18'h00000);
        flags(4'hA);
        // Drain with a slow consumer, then empty again
        rd_want <= 1'b1;
        for (n = 0; n < 3000 && exp_q.size() > 0; n++) @(posedge sys_clk);
        if (n == 3000) give_up();
        rd_want <= 1'b0;
        repeat (5) @(posedge sys_clk);
        flags(4'h5);
        stop_test();
    end
endmodule : bcf_top_tb
